// ---- hdl/fsap_status_protect.sv ----
`timescale 1ns/1ps
`include "fsap_cfg.svh"

// Overview of operation
// - Inverted, upper bits 00: codes 1-6 protect lower 63/64 down to 1/2.
// - Inverted, upper bits 01: codes 1-6 protect upper 63/64 down to 1/2.
// - Inverted, upper bits 10: all protected except top 4K to 32K.
// - Inverted, upper bits 11: all protected except bottom 4K to 32K.
// - Invert bit defaults 0; inverted code 0 protects all, code 7 none.
// - Busy bit is 1 during program, wipe or status write.
// - Write latch bit mirrors latch; clear latch refuses all writes.
// - Level bits set only by status write; region refuses program and wipes.
// - Whole wipe only with codes all 0 uninverted or all 1 inverted.
// - Guard pair 00: status write accepted when the latch is set and not busy.
// - Guard pair 10: status writes blocked until power cycle clears pair.
// - Guard pair 11: status writes blocked until power cycle clears pair, as for 10.
// - Quad bit always reads 1 and ignores writes.
// - Lock bits default 0, set one by one, cleared only by power cycle.
// - Suspend command sets wipe or program paused flag.
// - Resume, software reset pair and power cycle clear paused flags.
// - Latch clears on power-up, reset, latch off, status write, program, wipes.
// - Uninverted codes select the plain regions; 0 none, 7 everything.

module fsap_status_protect #(
   parameter int WRITE_STATUS_CYCLES = 40,
   parameter int PROGRAM_CYCLES      = 200,
   parameter int WIPE_CYCLES         = 1000
) (
   // clock and reset
   input  wire logic                    mclk,
   input  wire logic                    rst,
   // serial link
   input  wire logic                    sclk,
   input  wire logic                    cs_n,
   input  wire logic                    si,
   output logic                         so,
   output logic                         so_oe,
   // observed state
   output logic [15:0]                  status,
   output fsap_pkg::fsap_array_op_s     array_op
);

   // link synchronisers
   logic sclk_s1;
   logic sclk_s2;
   logic sclk_s3;
   logic cs_s1;
   logic cs_s2;
   logic cs_s3;
   logic si_s1;
   logic si_s2;

   // three sclk stages so edges are found off the second one
   always_ff @(posedge mclk) begin
      if (rst) begin
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_s3 <= 1'b0;
         cs_s1   <= 1'b1;
         cs_s2   <= 1'b1;
         cs_s3   <= 1'b1;
         si_s1   <= 1'b0;
         si_s2   <= 1'b0;
      end else begin
         sclk_s1 <= sclk;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         cs_s1   <= cs_n;
         cs_s2   <= cs_s1;
         cs_s3   <= cs_s2;
         si_s1   <= si;
         si_s2   <= si_s1;
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic frame_on;
   logic frame_end;

   // edge flags on the synchronised link
   assign sclk_rise = sclk_s2 && !sclk_s3;
   assign sclk_fall = !sclk_s2 && sclk_s3;
   assign frame_on  = !cs_s2;
   assign frame_end = cs_s2 && !cs_s3;

   // frame group
   logic [2:0]  bit_cnt;
   logic [2:0]  next_bit_cnt;
   logic [2:0]  byte_cnt;
   logic [2:0]  next_byte_cnt;
   logic [7:0]  shifter;
   logic [7:0]  next_shifter;
   logic [7:0]  cmd;
   logic [7:0]  next_cmd;
   logic [23:0] addr;
   logic [23:0] next_addr;
   logic [7:0]  data_lo;
   logic [7:0]  next_data_lo;
   logic [7:0]  data_hi;
   logic [7:0]  next_data_hi;
   logic [2:0]  out_idx;
   logic [2:0]  next_out_idx;
   logic        next_so;
   logic        next_so_oe;
   logic [7:0]  in_byte;
   logic [7:0]  rd_byte;
   logic        reading;

   // byte assembly and status readout
   always_comb begin
      next_bit_cnt  = bit_cnt;
      next_byte_cnt = byte_cnt;
      next_shifter  = shifter;
      next_cmd      = cmd;
      next_addr     = addr;
      next_data_lo  = data_lo;
      next_data_hi  = data_hi;
      next_out_idx  = out_idx;
      next_so       = so;
      next_so_oe    = so_oe;
      in_byte       = {shifter[6:0], si_s2};
      rd_byte       = (cmd == `FSAP_CMD_READ_HI) ? status[15:8] : status[7:0];
      reading       = cmd == `FSAP_CMD_READ_LO || cmd == `FSAP_CMD_READ_HI;
      if (!frame_on) begin
         next_bit_cnt  = `FSAP_BIT_FIRST;
         next_byte_cnt = '0;
         next_so_oe    = 1'b0;
      end
      if (frame_on && sclk_rise) begin
         next_shifter = in_byte;
         next_bit_cnt = bit_cnt + `FSAP_CODE_STEP;
         if (bit_cnt == `FSAP_BIT_LAST) begin
            // count saturates; long program data needs no more than a flag
            if (byte_cnt != `FSAP_N_SAT) begin
               next_byte_cnt = byte_cnt + `FSAP_CODE_STEP;
            end
            if (byte_cnt == '0) begin
               next_cmd     = in_byte;
               next_out_idx = `FSAP_BIT_LAST;
            end
            if (byte_cnt == `FSAP_N_CMD) begin
               next_addr[23:16] = in_byte;
               next_data_lo     = in_byte;
            end
            if (byte_cnt == `FSAP_N_STATUS_LO) begin
               next_addr[15:8] = in_byte;
               next_data_hi    = in_byte;
            end
            if (byte_cnt == `FSAP_N_STATUS_HI) begin
               next_addr[7:0] = in_byte;
            end
         end
      end
      // live status is shifted so busy polling sees fresh values
      if (frame_on && sclk_fall && byte_cnt != '0 && reading) begin
         next_so      = rd_byte[out_idx];
         next_so_oe   = 1'b1;
         next_out_idx = out_idx - `FSAP_CODE_STEP;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         bit_cnt  <= `FSAP_BIT_FIRST;
         byte_cnt <= '0;
         shifter  <= '0;
         cmd      <= '0;
         addr     <= '0;
         data_lo  <= '0;
         data_hi  <= '0;
         out_idx  <= `FSAP_BIT_LAST;
         so       <= 1'b0;
         so_oe    <= 1'b0;
      end else begin
         bit_cnt  <= next_bit_cnt;
         byte_cnt <= next_byte_cnt;
         shifter  <= next_shifter;
         cmd      <= next_cmd;
         addr     <= next_addr;
         data_lo  <= next_data_lo;
         data_hi  <= next_data_hi;
         out_idx  <= next_out_idx;
         so       <= next_so;
         so_oe    <= next_so_oe;
      end
   end

   // control group
   fsap_pkg::fsap_busy_e     state;
   fsap_pkg::fsap_busy_e     next_state;
   fsap_pkg::fsap_nv_s       nv;
   fsap_pkg::fsap_nv_s       next_nv;
   fsap_pkg::fsap_array_op_s next_op;
   logic [15:0]              busy_cnt;
   logic [15:0]              next_busy_cnt;
   logic                     write_latch_flag;
   logic                     next_wel;
   logic                     armed;
   logic                     next_armed;
   logic [15:0]              next_status;
   logic [15:0]              wr_word;
   logic                     frame_ok;
   logic                     is_busy;
   logic                     op_ready;
   logic                     hit;
   logic                     chip_ok;

   fsap_range_decode u_decode (
      .level   (nv.level),
      .invert  (nv.invert),
      .addr    (addr),
      .hit     (hit),
      .chip_ok (chip_ok)
   );

   // a frame cut off mid-byte is dropped as a whole
   assign frame_ok = frame_end && bit_cnt == `FSAP_BIT_FIRST && byte_cnt != '0;
   assign is_busy  = state inside {fsap_pkg::ST_WRITE_STATUS, fsap_pkg::ST_PROGRAM,
                                   fsap_pkg::ST_WIPE};
   assign wr_word  = {data_hi, data_lo};
   // a paused operation also blocks new array work
   assign op_ready = state == fsap_pkg::ST_IDLE && write_latch_flag;

   // command execution and busy timing
   always_comb begin
      next_state    = state;
      next_busy_cnt = busy_cnt;
      next_wel      = write_latch_flag;
      next_armed    = armed;
      next_nv       = nv;
      next_op       = '0;
      if (is_busy) begin
         if (busy_cnt == '0) begin
            next_state = fsap_pkg::ST_IDLE;
         end else begin
            next_busy_cnt = busy_cnt - 16'h1;
         end
      end
      if (frame_ok) begin
         next_armed = 1'b0;
         unique case (cmd)
            `FSAP_CMD_LATCH_ON: begin
               if (!is_busy) next_wel = 1'b1;
            end
            `FSAP_CMD_LATCH_OFF: begin
               if (!is_busy) next_wel = 1'b0;
            end
            `FSAP_CMD_WR_STATUS: begin
               if (!is_busy && write_latch_flag && byte_cnt >= `FSAP_N_STATUS_LO) begin
                  next_wel = 1'b0;
                  if (!nv.guard_high) begin
                     next_nv.level     = wr_word[`FSAP_S_LEVEL_HI:`FSAP_S_LEVEL_LO];
                     next_nv.guard_low = wr_word[`FSAP_S_GUARD_LO];
                     if (byte_cnt >= `FSAP_N_STATUS_HI) begin
                        next_nv.guard_high = wr_word[`FSAP_S_GUARD_HI];
                        next_nv.invert     = wr_word[`FSAP_S_INVERT];
                        next_nv.lock = nv.lock | wr_word[`FSAP_S_LOCK_HI:`FSAP_S_LOCK_LO];
                     end
                     next_state    = fsap_pkg::ST_WRITE_STATUS;
                     next_busy_cnt = 16'(WRITE_STATUS_CYCLES - 1);
                  end
               end
            end
            `FSAP_CMD_PROGRAM: begin
               if (op_ready && byte_cnt >= `FSAP_N_PROGRAM) begin
                  next_wel = 1'b0;
                  if (!hit) begin
                     next_op.valid = 1'b1;
                     next_op.kind  = fsap_pkg::OP_PROGRAM;
                  end
               end
            end
            `FSAP_CMD_SECTOR, `FSAP_CMD_BLK32, `FSAP_CMD_BLK64: begin
               if (op_ready && byte_cnt >= `FSAP_N_ADDR) begin
                  next_wel = 1'b0;
                  if (!hit) begin
                     next_op.valid = 1'b1;
                     next_op.kind  = (cmd == `FSAP_CMD_SECTOR) ? fsap_pkg::OP_SECTOR :
                                     (cmd == `FSAP_CMD_BLK32) ? fsap_pkg::OP_BLOCK32 :
                                     fsap_pkg::OP_BLOCK64;
                  end
               end
            end
            `FSAP_CMD_CHIP_A, `FSAP_CMD_CHIP_B: begin
               if (op_ready) begin
                  next_wel = 1'b0;
                  if (chip_ok) begin
                     next_op.valid = 1'b1;
                     next_op.kind  = fsap_pkg::OP_CHIP;
                  end
               end
            end
            `FSAP_CMD_SUSPEND: begin
               if (state == fsap_pkg::ST_PROGRAM) next_state = fsap_pkg::ST_PROGRAM_PAUSED;
               if (state == fsap_pkg::ST_WIPE) next_state = fsap_pkg::ST_WIPE_PAUSED;
            end
            `FSAP_CMD_RESUME: begin
               if (state == fsap_pkg::ST_PROGRAM_PAUSED) next_state = fsap_pkg::ST_PROGRAM;
               if (state == fsap_pkg::ST_WIPE_PAUSED) next_state = fsap_pkg::ST_WIPE;
            end
            `FSAP_CMD_RST_ARM: begin
               next_armed = 1'b1;
            end
            `FSAP_CMD_RST_GO: begin
               // reset abandons any running or paused operation
               if (armed) begin
                  next_state    = fsap_pkg::ST_IDLE;
                  next_busy_cnt = '0;
                  next_wel      = 1'b0;
               end
            end
            default: ;
         endcase
      end
      if (next_op.valid) begin
         next_op.addr  = addr;
         next_state    = (next_op.kind == fsap_pkg::OP_PROGRAM) ? fsap_pkg::ST_PROGRAM :
                         fsap_pkg::ST_WIPE;
         next_busy_cnt = (next_op.kind == fsap_pkg::OP_PROGRAM) ?
                         16'(PROGRAM_CYCLES - 1) : 16'(WIPE_CYCLES - 1);
      end
   end

   // status word built from next values so it tracks state with no lag
   always_comb begin
      next_status = '0;
      next_status[`FSAP_S_BUSY]  = next_state inside {fsap_pkg::ST_WRITE_STATUS,
                                   fsap_pkg::ST_PROGRAM, fsap_pkg::ST_WIPE};
      next_status[`FSAP_S_LATCH] = next_wel;
      next_status[`FSAP_S_LEVEL_HI:`FSAP_S_LEVEL_LO] = next_nv.level;
      next_status[`FSAP_S_GUARD_LO]   = next_nv.guard_low;
      next_status[`FSAP_S_GUARD_HI]   = next_nv.guard_high;
      next_status[`FSAP_S_QUAD]       = 1'b1;
      next_status[`FSAP_S_PROG_PAUSE] = next_state == fsap_pkg::ST_PROGRAM_PAUSED;
      next_status[`FSAP_S_LOCK_HI:`FSAP_S_LOCK_LO] = next_nv.lock;
      next_status[`FSAP_S_INVERT]     = next_nv.invert;
      next_status[`FSAP_S_WIPE_PAUSE] = next_state == fsap_pkg::ST_WIPE_PAUSED;
   end

   // reset stands for a power cycle: guard pair and invert bit return to 0
   always_ff @(posedge mclk) begin
      if (rst) begin
         state    <= fsap_pkg::ST_IDLE;
         busy_cnt <= '0;
         write_latch_flag      <= 1'b0;
         armed    <= 1'b0;
         nv       <= '0;
         array_op <= '0;
         status   <= `FSAP_STATUS_RESET;
      end else begin
         state    <= next_state;
         busy_cnt <= next_busy_cnt;
         write_latch_flag      <= next_wel;
         armed    <= next_armed;
         nv       <= next_nv;
         array_op <= next_op;
         status   <= next_status;
      end
   end

   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   a_op_needs_latch: assert property (array_op.valid |-> $past(write_latch_flag) && !$past(is_busy))
      else $error("array operation started without write latch");
   a_op_clears_latch: assert property (array_op.valid |-> !status[`FSAP_S_LATCH])
      else $error("write latch still set after array operation");
   a_op_outside_range: assert property (
      array_op.valid && array_op.kind != fsap_pkg::OP_CHIP |-> !$past(hit))
      else $error("array operation started inside protected region");
   a_chip_wipe_gate: assert property (array_op.valid && array_op.kind == fsap_pkg::OP_CHIP
      |-> (nv.level[2:0] == `FSAP_CODE_NONE && !nv.invert) ||
          (nv.level[2:0] == `FSAP_CODE_ALL && nv.invert))
      else $error("whole wipe accepted with protection active");
   a_busy_held: assert property (array_op.valid |-> status[`FSAP_S_BUSY] ##1
      status[`FSAP_S_BUSY])
      else $error("busy flag not raised for array operation");
   a_quad_fixed: assert property (status[`FSAP_S_QUAD])
      else $error("quad bit not one");
   // power-cycle reset may drop locks; the edge right after it is not judged
   a_lock_sticky: assert property (!$past(rst) |-> ($past(nv.lock) & ~nv.lock) == 3'h0)
      else $error("security lock bit cleared");
   a_guard_blocks: assert property (frame_ok && cmd == `FSAP_CMD_WR_STATUS
      && nv.guard_high |=> nv == $past(nv) && !status[`FSAP_S_BUSY])
      else $error("status written while guard locked");
   a_status_accept: assert property (frame_ok && cmd == `FSAP_CMD_WR_STATUS && write_latch_flag &&
      !is_busy && byte_cnt >= `FSAP_N_STATUS_LO && !nv.guard_high
      |=> status[`FSAP_S_BUSY] && !status[`FSAP_S_LATCH])
      else $error("status write with latch set not accepted");
   a_suspend_flag: assert property (frame_ok && cmd == `FSAP_CMD_SUSPEND &&
      state == fsap_pkg::ST_PROGRAM |=> status[`FSAP_S_PROG_PAUSE] && !status[`FSAP_S_BUSY])
      else $error("program suspend flag not set");
   a_resume_clears: assert property (frame_ok && cmd == `FSAP_CMD_RESUME
      |=> !status[`FSAP_S_PROG_PAUSE] && !status[`FSAP_S_WIPE_PAUSE])
      else $error("paused flag survives resume");
   a_invert_all: assert property (nv.invert && nv.level[2:0] == `FSAP_CODE_NONE |-> hit)
      else $error("inverted code zero leaves address open");
   a_plain_none: assert property (!nv.invert && nv.level[2:0] == `FSAP_CODE_NONE |-> !hit)
      else $error("plain code zero protects an address");

   c_program: cover property (array_op.valid && array_op.kind == fsap_pkg::OP_PROGRAM);
   c_chip_wipe: cover property (array_op.valid && array_op.kind == fsap_pkg::OP_CHIP);
   c_suspend: cover property (status[`FSAP_S_WIPE_PAUSE]);
   c_guard_refused: cover property (frame_ok && cmd == `FSAP_CMD_WR_STATUS && nv.guard_high);

endmodule

// ---- hdl/fsap_cfg.svh ----
`ifndef FSAP_CFG_SVH
`define FSAP_CFG_SVH

// array geometry and protect spans
`define FSAP_ARRAY_BYTES     24'h800000
`define FSAP_SPAN_FRACT      24'h020000
`define FSAP_SPAN_SMALL      24'h001000
`define FSAP_SPAN_SMALL_MAX  24'h008000

// protect code corners on the low three level bits
`define FSAP_CODE_NONE       3'h0
`define FSAP_CODE_ALL        3'h7
`define FSAP_CODE_STEP       3'h1

// status word bit positions
`define FSAP_S_BUSY          0
`define FSAP_S_LATCH         1
`define FSAP_S_LEVEL_LO      2
`define FSAP_S_LEVEL_HI      6
`define FSAP_S_GUARD_LO      7
`define FSAP_S_GUARD_HI      8
`define FSAP_S_QUAD          9
`define FSAP_S_PROG_PAUSE    10
`define FSAP_S_LOCK_LO       11
`define FSAP_S_LOCK_HI       13
`define FSAP_S_INVERT        14
`define FSAP_S_WIPE_PAUSE    15
`define FSAP_STATUS_RESET    16'h0200

// command codes
`define FSAP_CMD_LATCH_ON    8'h06
`define FSAP_CMD_LATCH_OFF   8'h04
`define FSAP_CMD_READ_LO     8'h05
`define FSAP_CMD_READ_HI     8'h35
`define FSAP_CMD_WR_STATUS   8'h01
`define FSAP_CMD_PROGRAM     8'h02
`define FSAP_CMD_SECTOR      8'h20
`define FSAP_CMD_BLK32       8'h52
`define FSAP_CMD_BLK64       8'hD8
`define FSAP_CMD_CHIP_A      8'hC7
`define FSAP_CMD_CHIP_B      8'h60
`define FSAP_CMD_SUSPEND     8'h75
`define FSAP_CMD_RESUME      8'h7A
`define FSAP_CMD_RST_ARM     8'h66
`define FSAP_CMD_RST_GO      8'h99

// frame byte counts and bit counter marks
`define FSAP_N_CMD           3'h1
`define FSAP_N_STATUS_LO     3'h2
`define FSAP_N_STATUS_HI     3'h3
`define FSAP_N_ADDR          3'h4
`define FSAP_N_PROGRAM       3'h5
`define FSAP_N_SAT           3'h7
`define FSAP_BIT_FIRST       3'h0
`define FSAP_BIT_LAST        3'h7

`endif

// ---- hdl/fsap_pkg.sv ----
package fsap_pkg;

   // kind of array operation started
   typedef enum logic [2:0] {
      OP_PROGRAM,
      OP_SECTOR,
      OP_BLOCK32,
      OP_BLOCK64,
      OP_CHIP
   } fsap_op_e;

   // one-cycle report of an accepted array operation
   typedef struct packed {
      logic        valid;
      fsap_op_e    kind;
      logic [23:0] addr;
   } fsap_array_op_s;

   // non-volatile status fields
   typedef struct packed {
      logic       guard_high;
      logic       guard_low;
      logic       invert;
      logic [2:0] lock;
      logic [4:0] level;
   } fsap_nv_s;

   // busy and suspend state
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WRITE_STATUS,
      ST_PROGRAM,
      ST_WIPE,
      ST_PROGRAM_PAUSED,
      ST_WIPE_PAUSED
   } fsap_busy_e;

endpackage

// ---- hdl/fsap_range_decode.sv ----
`timescale 1ns/1ps
`include "fsap_cfg.svh"

module fsap_range_decode (
   // protect settings
   input  wire logic [4:0]  level,
   input  wire logic        invert,
   // target address
   input  wire logic [23:0] addr,
   // verdict
   output logic             hit,
   output logic             chip_ok
);

   logic [2:0]  code;
   logic [23:0] span;
   logic        in_region;

   // level[3] picks low end, level[4] picks small spans
   always_comb begin
      code = level[2:0];
      if (!level[4]) begin
         span = `FSAP_SPAN_FRACT << (code - `FSAP_CODE_STEP);
      end else if (code[2]) begin
         span = `FSAP_SPAN_SMALL_MAX;
      end else begin
         span = `FSAP_SPAN_SMALL << (code - `FSAP_CODE_STEP);
      end
      if (code == `FSAP_CODE_NONE) begin
         in_region = 1'b0;
      end else if (code == `FSAP_CODE_ALL) begin
         in_region = 1'b1;
      end else if (level[3]) begin
         in_region = addr < span;
      end else begin
         in_region = addr >= (`FSAP_ARRAY_BYTES - span);
      end
      // inversion turns each region into its complement
      hit = in_region ^ invert;
      chip_ok = (code == `FSAP_CODE_NONE && !invert) ||
                (code == `FSAP_CODE_ALL && invert);
   end

endmodule

// ---- test/fsap_host_model.sv ----
`timescale 1ns/1ps
// host controller side of the link: mode 0, sclk parked low between frames
module fsap_host_model (
   // system clock
   input  wire logic mclk,
   // link
   output logic      sclk,
   output logic      cs_n,
   output logic      si,
   input  wire logic so
);
   // idle link at time zero
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
   end

   // nb bytes of d, msb first; rd holds the last eight bits seen on so
   task automatic xfer(input logic [39:0] d, input int nb, output logic [7:0] rd);
      cs_n <= 1'b0;
      for (int i = 0; i < nb * 8; i++) begin
         si <= d[39 - i];
         repeat (4) @(posedge mclk);
         sclk <= 1'b1;
         rd = {rd[6:0], so};
         repeat (4) @(posedge mclk);
         sclk <= 1'b0;
      end
      repeat (4) @(posedge mclk);
      cs_n <= 1'b1;
      si   <= ~si; // deselected line must not keep a stale bit
      repeat (6) @(posedge mclk);
   endtask
endmodule

// ---- test/tb_fsap_status_protect.sv ----
`timescale 1ns/1ps
module tb_fsap_status_protect;
   // clock, reset, link and observed state
   logic                     mclk;
   logic                     rst;
   logic                     sclk;
   logic                     cs_n;
   logic                     si;
   logic                     so;
   logic                     so_oe;
   logic                     so_line;
   logic [15:0]              status;
   fsap_pkg::fsap_array_op_s array_op;
   fsap_pkg::fsap_array_op_s op_seen;
   logic [7:0]               rd;
   int                       error_cnt;
   int                       check_count;

   // wipe and status write counts shortened; suspend needs ops to outlast a one-byte frame
   fsap_status_protect #(
      .WRITE_STATUS_CYCLES(20),
      .PROGRAM_CYCLES(200),
      .WIPE_CYCLES(200)
   ) i_fsap_status_protect (
      .mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si),
      .so(so), .so_oe(so_oe), .status(status), .array_op(array_op)
   );

   // an undriven data line shows the inverse, so a missing enable corrupts reads
   assign so_line = so_oe ? so : ~so;

   fsap_host_model i_fsap_host_model (
      .mclk(mclk), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so_line)
   );

   // clock
   initial mclk = 1'b0;
   always #25 mclk = ~mclk;

   // keep the one-cycle operation report until the bench clears it
   always @(posedge mclk) begin
      if (array_op.valid === 1'b1) begin
         op_seen <= array_op;
      end
   end

   task automatic wrap_up;
      if (error_cnt == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [27:0] exp, input logic [27:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic send(input logic [39:0] d, input int nb);
      i_fsap_host_model.xfer(d, nb, rd);
   endtask

   // bounded busy poll; a hang closes the run
   task automatic wait_idle;
      int n;
      for (n = 0; n < 500 && status[0] !== 1'b0; n++) @(negedge mclk);
      if (n == 500) begin
         chk("busy timeout", 28'h0, 28'h1);
         wrap_up;
      end
      @(posedge mclk);
   endtask

   task automatic wsr(input logic [7:0] lo, input logic [7:0] hi);
      send(40'h0600000000, 1);
      send({8'h01, lo, hi, 16'h0000}, 3);
      wait_idle;
   endtask

   // a clear latch refuses writes; latch on and off
   task automatic t_latch;
      send(40'h0104000000, 3);
      chk("status", 16'h0200, status);
      op_seen <= '0;
      send(40'h02000000A5, 5);
      chk("op", 1'b0, op_seen.valid);
      send(40'h0600000000, 1);
      chk("status", 16'h0202, status);
      send(40'h0400000000, 1);
      chk("status", 16'h0200, status);
   endtask

   // entry: level, invert, accepted, pad | command | target address
   task automatic t_protect;
      logic [39:0] tbl [20];
      logic [39:0] e;
      logic [2:0]  k;
      tbl = '{40'h0C027DFFFF, 40'h0E027E0000, 40'h4C20020000, 40'h4E2001FFFF,
              40'hA4527F7FFF, 40'hA6527F8000, 40'hB4027F7FFF, 40'hCCD8001000,
              40'hCED8000FFF, 40'h04027FFFFF, 40'h3E02000000, 40'h08027E0000,
              40'h0A027DFFFF, 40'h88207FF000, 40'h8A207FEFFF, 40'h02C7000000,
              40'h0860000000, 40'h3E60000000, 40'h38C7000000, 40'hBEC7000000};
      foreach (tbl[i]) begin
         e = tbl[i];
         wsr({1'b0, e[39:35], 2'h0}, {1'b0, e[34], 6'h00});
         chk("status", {1'b0, e[34], 6'h02, 1'b0, e[39:35], 2'h0}, status);
         case (e[31:24])
            8'h02: k = fsap_pkg::OP_PROGRAM;
            8'h20: k = fsap_pkg::OP_SECTOR;
            8'h52: k = fsap_pkg::OP_BLOCK32;
            8'hD8: k = fsap_pkg::OP_BLOCK64;
            default: k = fsap_pkg::OP_CHIP;
         endcase
         send(40'h0600000000, 1);
         op_seen <= '0;
         send({e[31:0], 8'hA5},
              (k == fsap_pkg::OP_PROGRAM) ? 5 : (k == fsap_pkg::OP_CHIP) ? 1 : 4);
         chk("op", e[33] ? {1'b1, k} : 4'h0,
             {op_seen.valid, op_seen.kind});
         if (e[33] && k != fsap_pkg::OP_CHIP) chk("addr", e[23:0], op_seen.addr);
         chk("busy latch", {1'b0, e[33]}, status[1:0]);
         wait_idle;
      end
   endtask

   // wipe suspended and resumed, program suspended and reset
   task automatic t_suspend;
      wsr(8'h00, 8'h00);
      send(40'h0600000000, 1);
      send(40'hD800000000, 4);
      send(40'h7500000000, 1);
      chk("status", 16'h8200, status);
      send(40'h7A00000000, 1);
      chk("status", 16'h0201, status);
      wait_idle;
      send(40'h0600000000, 1);
      send(40'h02000100A5, 5);
      send(40'h7500000000, 1);
      chk("status", 16'h0600, status);
      send(40'h6600000000, 1);
      send(40'h9900000000, 1);
      chk("status", 16'h0200, status);
   endtask

   // locks stick, quad fixed, guard modes, serial read back
   task automatic t_guard;
      wsr(8'h00, 8'h08);
      wsr(8'h00, 8'h00);
      chk("status", 16'h0A00, status);
      wsr(8'h00, 8'h01);
      wsr(8'h04, 8'h00);
      chk("status", 16'h0B00, status);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("status", 16'h0200, status);
      wsr(8'h80, 8'h01);
      wsr(8'h04, 8'h00);
      chk("status", 16'h0380, status);
      send(40'h3500000000, 2);
      chk("read hi", 8'h03, rd);
      send(40'h0500000000, 2);
      chk("read lo", 8'h80, rd);
   endtask

   // main sequence
   initial begin
      rst = 1'b1;
      error_cnt = 0;
      check_count = 0;
      op_seen = '0;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("reset status", 16'h0200, status);
      t_latch;
      t_protect;
      t_suspend;
      t_guard;
      wrap_up;
   end
endmodule
